/* core/pps_top.sv */
`default_nettype none
module pps_top #(
   parameter int LOCK_WINDOW = pps_pkg::LOCK_WINDOW,
   parameter int LOCK_RATIO  = 16,
   parameter int LOCK_TOL    = 4,
   parameter int DATA_W      = 10
) (
   // Clock and reset.
   input  wire logic                 aclk,
   input  wire logic                 aresetn,
   // AXI4-Lite register port.
   input  wire logic [31:0]          s_awaddr,
   input  wire logic                 s_awvalid,
   output logic                      s_awready,
   input  wire logic [31:0]          s_wdata,
   input  wire logic [3:0]           s_wstrb,
   input  wire logic                 s_wvalid,
   output logic                      s_wready,
   output logic [1:0]                s_bresp,
   output logic                      s_bvalid,
   input  wire logic                 s_bready,
   input  wire logic [31:0]          s_araddr,
   input  wire logic                 s_arvalid,
   output logic                      s_arready,
   output logic [31:0]               s_rdata,
   output logic [1:0]                s_rresp,
   output logic                      s_rvalid,
   input  wire logic                 s_rready,
   // MAC power control and status.
   input  wire pps_pkg::pps_mac_ctl_t mac_ctl,
   output logic                      phy_done,
   output logic [1:0]                power_state,
   output pps_pkg::pps_tx_ctl_t      tx_ctl,
   input  wire logic [2:0]           rx_status_raw,
   output logic [2:0]                pipe_status,
   // Data paths.
   input  wire logic [DATA_W-1:0]    tx_data,
   input  wire logic [DATA_W-1:0]    rm_data,
   output logic [DATA_W-1:0]         ser_data,
   // Receiver clocking and lock.
   input  wire logic                 cru_div_clk,
   output logic                      rx_lock_to_ref,
   output logic                      rx_lock_to_data,
   output logic                      freq_locked,
   output logic                      rm_bypass
);
   if (DATA_W < 1 || LOCK_WINDOW < 1) begin : g_bad
      $error("pps_top: unusable data width or lock window");
   end
   if (pps_pkg::FR_LTR_CYC < pps_pkg::FR_MIN_CYC || pps_pkg::FR_LTR_CYC >= pps_pkg::FR_MAX_CYC) begin : g_bad_fr
      $error("pps_top: fast recovery time outside the transition window");
   end

   localparam int          FW      = $clog2(pps_pkg::FR_LTR_CYC + 1);
   localparam logic [FW-1:0] FR_LAST = FW'(pps_pkg::FR_LTR_CYC - 1);

   ////////////////////////////////////////////////////////////////////////////
   // Registers and state.
   logic [pps_pkg::CTL_WIDTH-1:0] ctrl;
   logic                          illegal;
   pps_pkg::pps_state_t           state;
   pps_pkg::pps_state_t           next_state;
   logic                          was_p0s;
   logic [FW-1:0]                 fr_cnt;
   logic                          fr_active;
   logic                          restart;
   logic                          lock_raw;
   logic                          low_lat;
   logic                          illegal_now;
   logic                          aw_hold;
   logic                          w_hold;
   logic [31:0]                   aw_addr;
   logic [31:0]                   w_data;
   logic [3:0]                    w_strb;
   logic                          do_write;
   logic                          clr_illegal;
   logic [31:0]                   stat_word;

   assign low_lat = ctrl[pps_pkg::CTL_LOWLAT];

   ////////////////////////////////////////////////////////////////////////////
   // Power state decode.
   always_comb begin
      case (mac_ctl.power_req)
         pps_pkg::PD_P0:  next_state = pps_pkg::PPS_P0;
         pps_pkg::PD_P0S: next_state = pps_pkg::PPS_P0S;
         pps_pkg::PD_P1:  next_state = pps_pkg::PPS_P1;
         default:         next_state = pps_pkg::PPS_P2;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state       <= pps_pkg::PPS_P0;
         power_state <= pps_pkg::PD_P0;
         phy_done    <= 1'b0;
      end else begin
         state       <= next_state;
         power_state <= mac_ctl.power_req;
         // One pulse per change; a request held steady is not acknowledged
         // again, which is why the MAC does not wait for it before the next one.
         phy_done    <= (next_state != state);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Transmit behaviour in each state. The rest of the channel keeps running.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_ctl <= '0;
      end else begin
         tx_ctl <= '0;
         case (state)
            pps_pkg::PPS_P0: begin
               tx_ctl.elec_idle <= mac_ctl.force_idle;
               tx_ctl.loopback  <= mac_ctl.detect_loop && !low_lat;
            end
            pps_pkg::PPS_P0S: begin
               tx_ctl.elec_idle <= 1'b1;
            end
            pps_pkg::PPS_P1: begin
               tx_ctl.elec_idle <= 1'b1;
               tx_ctl.rx_detect <= mac_ctl.detect_loop;
            end
            pps_pkg::PPS_P2: begin
               tx_ctl.elec_idle <= mac_ctl.force_idle;
               tx_ctl.beacon    <= !mac_ctl.force_idle;
            end
            default: tx_ctl <= '0;
         endcase
      end
   end

   // The serializer takes rate-matched receive data while looping back.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ser_data <= '0;
      end else if (state == pps_pkg::PPS_P0 && mac_ctl.detect_loop && !low_lat) begin
         ser_data <= rm_data;
      end else begin
         ser_data <= tx_data;
      end
   end

   // A force-idle level that the MAC must not use in the current state.
   always_comb begin
      case (state)
         pps_pkg::PPS_P0:  illegal_now = mac_ctl.force_idle;
         pps_pkg::PPS_P0S: illegal_now = !mac_ctl.force_idle;
         pps_pkg::PPS_P1:  illegal_now = !mac_ctl.force_idle;
         default:          illegal_now = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Receive path: rate match bypass and status filtering.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rm_bypass   <= 1'b0;
         pipe_status <= pps_pkg::STS_RX_OK;
      end else begin
         rm_bypass <= low_lat;
         if (low_lat && (rx_status_raw == pps_pkg::STS_EB_OVF || rx_status_raw == pps_pkg::STS_EB_UDF)) begin
            pipe_status <= pps_pkg::STS_RX_OK;
         end else begin
            pipe_status <= rx_status_raw;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Receiver lock control.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         was_p0s <= 1'b0;
      end else begin
         was_p0s <= (state == pps_pkg::PPS_P0S);
      end
   end

   // A return to P0 from P0s starts a fresh frequency comparison.
   assign restart = (state == pps_pkg::PPS_P0) && (next_state == pps_pkg::PPS_P0) && was_p0s;

   pps_lock #(
      .WINDOW (LOCK_WINDOW),
      .RATIO  (LOCK_RATIO),
      .TOL    (LOCK_TOL)
   ) u_lock (
      .aclk        (aclk),
      .aresetn     (aresetn),
      .restart     (restart),
      .cru_div_clk (cru_div_clk),
      .freq_locked (lock_raw)
   );

   // Fast recovery skips the slow comparison: it holds lock-to-reference for a
   // fixed time well inside the window, then hands over to data.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fr_active <= 1'b0;
         fr_cnt    <= '0;
      end else if (restart && ctrl[pps_pkg::CTL_FAST] && !ctrl[pps_pkg::CTL_MANUAL]) begin
         fr_active <= 1'b1;
         fr_cnt    <= '0;
      end else if (fr_active) begin
         fr_cnt <= fr_cnt + FW'(1);
         if (fr_cnt == FR_LAST) begin
            fr_active <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_lock_to_ref  <= 1'b1;
         rx_lock_to_data <= 1'b0;
         freq_locked     <= 1'b0;
      end else begin
         freq_locked <= lock_raw;
         if (ctrl[pps_pkg::CTL_MANUAL]) begin
            rx_lock_to_ref  <= ctrl[pps_pkg::CTL_MAN_LTR];
            rx_lock_to_data <= ctrl[pps_pkg::CTL_MAN_LTD];
         end else if (ctrl[pps_pkg::CTL_FAST]) begin
            rx_lock_to_ref  <= fr_active || restart;
            rx_lock_to_data <= !(fr_active || restart);
         end else begin
            rx_lock_to_ref  <= !lock_raw;
            rx_lock_to_data <= lock_raw;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite slave. One write and one read at a time.
   assign do_write    = aw_hold && w_hold && !s_bvalid;
   assign clr_illegal = do_write && aw_addr == pps_pkg::ADDR_STAT && w_strb[0] && w_data[pps_pkg::ST_ILLEGAL];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold   <= 1'b0;
         w_hold    <= 1'b0;
         aw_addr   <= '0;
         w_data    <= '0;
         w_strb    <= '0;
         s_awready <= 1'b1;
         s_wready  <= 1'b1;
         s_bvalid  <= 1'b0;
         s_bresp   <= pps_pkg::RESP_OKAY;
      end else begin
         if (s_awvalid && s_awready) begin
            aw_hold   <= 1'b1;
            aw_addr   <= s_awaddr;
            s_awready <= 1'b0;
         end
         if (s_wvalid && s_wready) begin
            w_hold   <= 1'b1;
            w_data   <= s_wdata;
            w_strb   <= s_wstrb;
            s_wready <= 1'b0;
         end
         if (do_write) begin
            aw_hold  <= 1'b0;
            w_hold   <= 1'b0;
            s_bvalid <= 1'b1;
            s_bresp  <= (aw_addr == pps_pkg::ADDR_CTRL || aw_addr == pps_pkg::ADDR_STAT) ?
                        pps_pkg::RESP_OKAY : pps_pkg::RESP_SLVERR;
         end
         if (s_bvalid && s_bready) begin
            s_bvalid  <= 1'b0;
            s_awready <= 1'b1;
            s_wready  <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl <= pps_pkg::CTRL_RESET[pps_pkg::CTL_WIDTH-1:0];
      end else if (do_write && aw_addr == pps_pkg::ADDR_CTRL && w_strb[0]) begin
         ctrl <= w_data[pps_pkg::CTL_WIDTH-1:0];
      end
   end

   // A new violation in the clearing cycle keeps the flag set.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         illegal <= 1'b0;
      end else begin
         illegal <= illegal_now || (illegal && !clr_illegal);
      end
   end

   always_comb begin
      stat_word                                         = '0;
      stat_word[pps_pkg::ST_STATE+1:pps_pkg::ST_STATE] = power_state;
      stat_word[pps_pkg::ST_LOCKED]                     = freq_locked;
      stat_word[pps_pkg::ST_LTR]                        = rx_lock_to_ref;
      stat_word[pps_pkg::ST_LTD]                        = rx_lock_to_data;
      stat_word[pps_pkg::ST_LOOP]                       = tx_ctl.loopback;
      stat_word[pps_pkg::ST_ILLEGAL]                    = illegal;
      stat_word[pps_pkg::ST_BYPASS]                     = rm_bypass;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_arready <= 1'b1;
         s_rvalid  <= 1'b0;
         s_rdata   <= '0;
         s_rresp   <= pps_pkg::RESP_OKAY;
      end else if (s_arvalid && s_arready) begin
         s_arready <= 1'b0;
         s_rvalid  <= 1'b1;
         s_rresp   <= pps_pkg::RESP_OKAY;
         case (s_araddr)
            pps_pkg::ADDR_CTRL: s_rdata <= 32'(ctrl);
            pps_pkg::ADDR_STAT: s_rdata <= stat_word;
            default: begin
               s_rdata <= '0;
               s_rresp <= pps_pkg::RESP_SLVERR;
            end
         endcase
      end else if (s_rvalid && s_rready) begin
         s_rvalid  <= 1'b0;
         s_arready <= 1'b1;
      end
   end
endmodule : pps_top
`default_nettype wire

/* inc/pps_pkg.sv */
`default_nettype none
package pps_pkg;
   ////////////////////////////////////////////////////////////////////////////
   // Power state request codes and the one-hot channel state.
   localparam logic [1:0] PD_P0  = 2'h0;
   localparam logic [1:0] PD_P0S = 2'h1;
   localparam logic [1:0] PD_P1  = 2'h2;
   localparam logic [1:0] PD_P2  = 2'h3;

   typedef enum logic [3:0] {
      PPS_P0  = 4'h1,
      PPS_P0S = 4'h2,
      PPS_P1  = 4'h4,
      PPS_P2  = 4'h8
   } pps_state_t;

   ////////////////////////////////////////////////////////////////////////////
   // Register map, byte addresses.
   localparam logic [31:0] ADDR_CTRL  = 32'h0000_0000;
   localparam logic [31:0] ADDR_STAT  = 32'h0000_0004;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

   localparam int CTL_FAST    = 0;
   localparam int CTL_LOWLAT  = 1;
   localparam int CTL_MANUAL  = 2;
   localparam int CTL_MAN_LTR = 3;
   localparam int CTL_MAN_LTD = 4;
   localparam int CTL_WIDTH   = 5;

   localparam int ST_STATE   = 0;
   localparam int ST_LOCKED  = 2;
   localparam int ST_LTR     = 3;
   localparam int ST_LTD     = 4;
   localparam int ST_LOOP    = 5;
   localparam int ST_ILLEGAL = 6;
   localparam int ST_BYPASS  = 7;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   ////////////////////////////////////////////////////////////////////////////
   // Receiver status codes that depend on the rate match FIFO.
   localparam logic [2:0] STS_RX_OK  = 3'h0;
   localparam logic [2:0] STS_EB_OVF = 3'h5;
   localparam logic [2:0] STS_EB_UDF = 3'h6;

   ////////////////////////////////////////////////////////////////////////////
   // Timing at 200 MHz.
   localparam int CLK_PERIOD_PS = 5000;
   localparam int FR_MIN_NS     = 16;
   localparam int FR_MAX_NS     = 4000;
   localparam int FR_LTR_NS     = 1000;
   localparam int FR_MIN_CYC    = (FR_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int FR_MAX_CYC    = (FR_MAX_NS * 1000) / CLK_PERIOD_PS;
   localparam int FR_LTR_CYC    = (FR_LTR_NS * 1000) / CLK_PERIOD_PS;
   localparam int LOCK_WINDOW   = 32768;

   ////////////////////////////////////////////////////////////////////////////
   // Carriers.
   typedef struct packed {
      logic [1:0] power_req;
      logic       detect_loop;
      logic       force_idle;
   } pps_mac_ctl_t;

   typedef struct packed {
      logic elec_idle;
      logic beacon;
      logic rx_detect;
      logic loopback;
   } pps_tx_ctl_t;
endpackage : pps_pkg
`default_nettype wire

/* core/pps_sync.sv */
`default_nettype none
module pps_sync (
   // Clock and reset.
   input  wire logic aclk,
   input  wire logic aresetn,
   // Asynchronous level in, filtered level out.
   input  wire logic din,
   output logic      dout
);
   logic ff1;
   logic ff2;
   logic ff3;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ff1 <= 1'b0;
         ff2 <= 1'b0;
         ff3 <= 1'b0;
      end else begin
         ff1 <= din;
         ff2 <= ff1;
         ff3 <= ff2;
      end
   end

   // A change counts only once the last two stages agree.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dout <= 1'b0;
      end else if (ff2 == ff3) begin
         dout <= ff3;
      end
   end
endmodule : pps_sync
`default_nettype wire

/* core/pps_lock.sv */
`default_nettype none
module pps_lock #(
   parameter int WINDOW = 32768,
   parameter int RATIO  = 16,
   parameter int TOL    = 4
) (
   // Clock and reset.
   input  wire logic aclk,
   input  wire logic aresetn,
   // Control and recovered clock, divided by RATIO.
   input  wire logic restart,
   input  wire logic cru_div_clk,
   // Result.
   output logic      freq_locked
);
   localparam int          CW     = $clog2(WINDOW + 1);
   localparam logic [CW-1:0] EXPECT = CW'(WINDOW / RATIO);
   localparam logic [CW-1:0] LAST   = CW'(WINDOW - 1);

   if (RATIO < 4 || WINDOW < RATIO || TOL < 0) begin : g_bad
      $error("pps_lock: unusable window, ratio or tolerance");
   end

   logic          div_lvl;
   logic          div_prev;
   logic [CW-1:0] win_cnt;
   logic [CW-1:0] edge_cnt;
   logic          in_range;

   pps_sync u_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .din     (cru_div_clk),
      .dout    (div_lvl)
   );

   assign in_range = (edge_cnt + CW'(TOL) >= EXPECT) && (edge_cnt <= EXPECT + CW'(TOL));

   // Edges of the recovered clock are counted over all but the last cycle of a window of reference
   // cycles; the lock holds until the owner restarts the comparison.
   always_ff @(posedge aclk) begin
      if (!aresetn || restart) begin
         div_prev    <= 1'b0;
         win_cnt     <= '0;
         edge_cnt    <= '0;
         freq_locked <= 1'b0;
      end else begin
         div_prev <= div_lvl;
         if (win_cnt == LAST) begin
            win_cnt     <= '0;
            edge_cnt    <= '0;
            freq_locked <= freq_locked | in_range;
         end else begin
            win_cnt <= win_cnt + CW'(1);
            if (div_lvl && !div_prev) begin
               edge_cnt <= edge_cnt + CW'(1);
            end
         end
      end
   end
endmodule : pps_lock
`default_nettype wire

/* sim/pps_top_monitor.sv */
`default_nettype none
module pps_top_monitor #(
   parameter int DATA_W = 10
) (
   // Clock and reset.
   input wire logic                  aclk,
   input wire logic                  aresetn,
   // Watched ports.
   input wire pps_pkg::pps_mac_ctl_t mac_ctl,
   input wire logic                  phy_done,
   input wire logic [1:0]            power_state,
   input wire pps_pkg::pps_tx_ctl_t  tx_ctl,
   input wire logic [2:0]            pipe_status,
   input wire logic [DATA_W-1:0]     rm_data,
   input wire logic [DATA_W-1:0]     ser_data,
   input wire logic                  rm_bypass
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   ////////////////////////////////////////
   // The transmit controls lag state and select by one edge, so they are judged only once both held still.
   logic       dl1;
   logic       dl2;
   logic       rel;
   logic       quiet;
   logic [1:0] st1;
   always_ff @(posedge aclk) begin
      dl1 <= mac_ctl.detect_loop;
      dl2 <= dl1;
      rel <= aresetn;
      st1 <= power_state;
   end
   assign quiet = rel && dl1 == dl2 && st1 == power_state;
   ////////////////////////////////////////
   a_state_decode: assert property ($past(aresetn) |-> power_state == $past(mac_ctl.power_req))
      else $error("power state differs from request");
   a_done_after: assert property (power_state != $past(power_state) |-> phy_done)
      else $error("no done pulse after state change");
   a_done_pulse: assert property (phy_done |=> !phy_done)
      else $error("done pulse longer than one cycle");
   a_p0s_idle: assert property (quiet && power_state == pps_pkg::PD_P0S |-> tx_ctl == 4'h8)
      else $error("P0s output not idle only");
   a_p1_detect: assert property (quiet && power_state == pps_pkg::PD_P1 |-> tx_ctl == {2'h2, dl1, 1'h0})
      else $error("P1 output wrong");
   a_p2_quiet: assert property (quiet && power_state == pps_pkg::PD_P2 |->
      !tx_ctl.rx_detect && !tx_ctl.loopback && tx_ctl.elec_idle != tx_ctl.beacon)
      else $error("P2 output wrong");
   a_p0_loop: assert property (quiet && power_state == pps_pkg::PD_P0 && !rm_bypass
      && !$past(rm_bypass) |-> tx_ctl.loopback == dl1)
      else $error("P0 loopback does not follow select");
   a_loop_data: assert property (tx_ctl.loopback |-> ser_data == $past(rm_data))
      else $error("loopback data not from rate match");
   a_no_loop_ll: assert property (rm_bypass && $past(rm_bypass) |-> !tx_ctl.loopback)
      else $error("loopback in low latency mode");
   a_status_ll: assert property (rm_bypass [*3] |->
      pipe_status != pps_pkg::STS_EB_OVF && pipe_status != pps_pkg::STS_EB_UDF)
      else $error("buffer status in low latency mode");
   c_done: cover property (phy_done);
   c_loop: cover property (tx_ctl.loopback);
   c_beacon: cover property (tx_ctl.beacon);
endmodule : pps_top_monitor
bind pps_top pps_top_monitor #(.DATA_W(DATA_W)) i_mon (.aclk, .aresetn, .mac_ctl, .phy_done,
   .power_state, .tx_ctl, .pipe_status, .rm_data, .ser_data, .rm_bypass);
`default_nettype wire

/* sim/pps_mac_model.sv */
`default_nettype none
module pps_mac_model (
   // Clock and reset.
   input  wire logic                 aclk,
   input  wire logic                 aresetn,
   // Commands from the bench.
   input  wire logic                 go,
   input  wire logic [1:0]           req,
   input  wire logic                 dl,
   input  wire logic                 bcn,
   // Channel side.
   input  wire logic                 phy_done,
   output var pps_pkg::pps_mac_ctl_t mac_ctl
);
   logic [1:0] req_q;
   logic       busy;
   logic       idle;
   // A new request is held back until the last one was acknowledged.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         req_q <= 2'h0;
         busy  <= 1'h0;
      end else if (go && !busy) begin
         req_q <= req;
         // A repeated request gets no done pulse, so it must not wait.
         busy  <= (req != req_q);
      end else if (phy_done) begin
         busy <= 1'h0;
      end
   end
   assign idle = (req_q == pps_pkg::PD_P2) ? !bcn : (req_q != pps_pkg::PD_P0);
   assign mac_ctl = {req_q, dl, idle};
endmodule : pps_mac_model
`default_nettype wire

/* sim/testbench.sv */
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic                  aclk = 1'h0;
   logic                  aresetn = 1'h0;
   logic [31:0]           s_awaddr = '0, s_wdata = '0, s_araddr = '0, s_rdata;
   logic                  s_awvalid = 1'h0, s_wvalid = 1'h0, s_bready = 1'h0, s_arvalid = 1'h0, s_rready = 1'h0;
   logic                  s_awready, s_wready, s_bvalid, s_arready, s_rvalid, phy_done;
   logic [3:0]            s_wstrb = 4'hF;
   logic [1:0]            s_bresp, s_rresp, power_state, req = 2'h0;
   logic                  go = 1'h0, dl = 1'h0, bcn = 1'h0, cru_div_clk = 1'h0;
   logic                  rx_lock_to_ref, rx_lock_to_data, freq_locked, rm_bypass;
   logic [2:0]            rx_status_raw = 3'h0, pipe_status;
   logic [9:0]            tx_data = 10'h15A, rm_data = 10'h2A5, ser_data;
   pps_pkg::pps_mac_ctl_t mac_ctl;
   pps_pkg::pps_tx_ctl_t  tx_ctl;
   int                    mismatches = 0, check_count = 0;
   always #2.5 aclk = ~aclk;
   // Recovered clock divided by 16 gives 16 edges per 256-cycle window.
   always #40 cru_div_clk = ~cru_div_clk;
   pps_top #(.LOCK_WINDOW(256), .LOCK_RATIO(16), .LOCK_TOL(4), .DATA_W(10)) i_dut (.aclk, .aresetn,
      .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid,
      .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .mac_ctl,
      .phy_done, .power_state, .tx_ctl, .rx_status_raw, .pipe_status, .tx_data, .rm_data, .ser_data,
      .cru_div_clk, .rx_lock_to_ref, .rx_lock_to_data, .freq_locked, .rm_bypass);
   pps_mac_model i_mac (.aclk, .aresetn, .go, .req, .dl, .bcn, .phy_done, .mac_ctl);
   ////////////////////////////////////////
   task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", n, exp, seen);
      end
   endtask : chk
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : wrap_up
   task automatic hang;
      mismatches++;
      $display("Error timeout expected answer seen none");
      wrap_up();
   endtask : hang
   task automatic axw(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
      int n;
      @(posedge aclk);
      s_awaddr <= a;
      s_wdata <= d;
      s_awvalid <= 1'h1;
      s_wvalid <= 1'h1;
      s_bready <= 1'h1;
      for (n = 0; n < 50 && !s_bvalid; n++) begin
         @(posedge aclk);
         if (s_awready) s_awvalid <= 1'h0;
         if (s_wready) s_wvalid <= 1'h0;
      end
      if (n == 50) hang();
      s_bready <= 1'h0;
      chk("bresp", s_bresp, r);
   endtask : axw
   task automatic axr(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge aclk);
      s_araddr <= a;
      s_arvalid <= 1'h1;
      s_rready <= 1'h1;
      for (n = 0; n < 50 && !(s_rvalid && !s_arvalid); n++) begin
         @(posedge aclk);
         if (s_arready) s_arvalid <= 1'h0;
      end
      if (n == 50) hang();
      s_rready <= 1'h0;
      d = s_rdata;
      r = s_rresp;
   endtask : axr
   // Asks for a state and counts done pulses over the next ten cycles.
   task automatic pwr(input logic [1:0] r, input logic s, output int k);
      @(posedge aclk);
      req <= r;
      dl <= s;
      go <= 1'h1;
      @(posedge aclk);
      go <= 1'h0;
      k = 0;
      repeat (10) begin
         @(posedge aclk);
         #1 k += int'(phy_done === 1'h1);
      end
   endtask : pwr
   ////////////////////////////////////////
   task automatic t_regs;
      logic [31:0] d;
      logic [1:0]  r;
      axr(pps_pkg::ADDR_CTRL, d, r);
      chk("ctrl_reset", d, pps_pkg::CTRL_RESET);
      axw(pps_pkg::ADDR_CTRL, 32'h0000_0003, pps_pkg::RESP_OKAY);
      axr(pps_pkg::ADDR_CTRL, d, r);
      chk("ctrl_rw", {d[29:0], r}, 32'h0000_000C);
      axw(pps_pkg::ADDR_CTRL, 32'h0000_0000, pps_pkg::RESP_OKAY);
      axw(32'h0000_0010, 32'h0000_0003, pps_pkg::RESP_SLVERR);
      axr(32'h0000_0010, d, r);
      chk("unmapped", {d[29:0], r}, {30'h0, pps_pkg::RESP_SLVERR});
   endtask : t_regs
   task automatic t_states;
      logic [3:0] exp [2][4] = '{'{4'h0, 4'h8, 4'h8, 4'h8}, '{4'h1, 4'h8, 4'hA, 4'h8}};
      int k;
      for (int j = 0; j < 2; j++) begin
         for (int i = 1; i < 5; i++) begin
            pwr(2'(i % 4), j[0], k);
            chk("done_pulses", k, 1);
            chk("state", power_state, i % 4);
            chk("tx_ctl", tx_ctl, exp[j][i % 4]);
            if (i == 3) begin
               @(posedge aclk);
               bcn <= 1'h1;
               repeat (4) @(posedge aclk);
               #1 chk("beacon", tx_ctl, 4'h4);
               @(posedge aclk);
               bcn <= 1'h0;
            end
         end
         chk("ser_data", ser_data, j ? rm_data : tx_data);
      end
   endtask : t_states
   task automatic t_lowlat;
      logic [2:0]  raw [3] = '{3'h5, 3'h6, 3'h7};
      logic [31:0] d;
      logic [1:0]  r;
      int          k;
      for (int m = 0; m < 2; m++) begin
         axw(pps_pkg::ADDR_CTRL, 32'(m) << pps_pkg::CTL_LOWLAT, pps_pkg::RESP_OKAY);
         for (int i = 0; i < 3; i++) begin
            @(posedge aclk);
            rx_status_raw <= raw[i];
            repeat (8) @(posedge aclk);
            #1 chk("pipe_status", pipe_status, (m && i < 2) ? 3'h0 : raw[i]);
         end
         @(posedge aclk);
         rx_status_raw <= 3'h0;
         axr(pps_pkg::ADDR_STAT, d, r);
         chk("stat_bypass", d[pps_pkg::ST_BYPASS], m);
         chk("bypass", rm_bypass, m);
         pwr(pps_pkg::PD_P0, 1'h1, k);
         chk("loopback", tx_ctl.loopback, !m);
         chk("ser_loop", ser_data, m ? tx_data : rm_data);
         pwr(pps_pkg::PD_P0, 1'h0, k);
      end
      axw(pps_pkg::ADDR_CTRL, 32'h0000_0000, pps_pkg::RESP_OKAY);
   endtask : t_lowlat
   task automatic t_lock;
      int k;
      int n;
      for (int f = 0; f < 2; f++) begin
         axw(pps_pkg::ADDR_CTRL, 32'(f), pps_pkg::RESP_OKAY);
         pwr(pps_pkg::PD_P0S, 1'h0, k);
         pwr(pps_pkg::PD_P0, 1'h0, k);
         chk("ltr_first", {rx_lock_to_ref, rx_lock_to_data}, 2'h2);
         for (n = 10; n < 3000 && rx_lock_to_data !== 1'h1; n++) @(posedge aclk);
         if (n == 3000) hang();
         if (f == 0) chk("lock_wait", {freq_locked, n >= 256}, 2'h3);
         else chk("fast_wait", n >= pps_pkg::FR_MIN_CYC && n <= pps_pkg::FR_MAX_CYC, 1);
      end
      for (int i = 0; i < 2; i++) begin
         axw(pps_pkg::ADDR_CTRL, i ? 32'h0000_000D : 32'h0000_0015, pps_pkg::RESP_OKAY);
         repeat (4) @(posedge aclk);
         #1 chk("manual", {rx_lock_to_ref, rx_lock_to_data}, i ? 2'h2 : 2'h1);
      end
      axw(pps_pkg::ADDR_CTRL, 32'h0000_0000, pps_pkg::RESP_OKAY);
   endtask : t_lock
   ////////////////////////////////////////
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      t_regs();
      t_states();
      t_lowlat();
      t_lock();
      wrap_up();
   end
endmodule : testbench
`default_nettype wire
